// [rtl/memdec_pkg.sv]
// Constants, types and helper functions shared by the memory space decoder files.
// What this block does
// - Low internal RAM 00H..7FH answers both direct and indirect data accesses.
// - Above 7FH, indirect accesses hit upper RAM and direct accesses hit the SFR port.
// - With expanded RAM enabled, external moves to 000H..2FFH hit on-chip 768-byte RAM.
// - Expanded RAM address comes from index register zero, one or the data pointer.
// - Expanded RAM accesses leave port buses and write/read strobes idle.
// - With expanded RAM enabled, external moves above 2FFH use the external multiplexed bus.
// - Index register external moves drive an 8-bit address multiplexed on the low port.
// - Data pointer external moves drive a full 16-bit address over 64K.
// - Two-bit bank field in flash_config chooses the 64K/8K flash block mapping.
// - Both flash blocks use 128-byte sectors: 512 primary, 64 secondary.
// - Program address bits 6..0 pick the byte, upper bits pick the sector.
package memdec_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [9:0] FLASH_CONFIG_IDX = 10'h0B1;
    localparam logic [9:0] AUX_CONFIG_IDX = 10'h0C0;
    localparam logic [9:0] STATUS_IDX = 10'h0C1;
    localparam logic [7:0] FLASH_CONFIG_RESET = 8'h00;
    localparam logic [7:0] FLASH_CONFIG_WMASK = 8'h43;
    localparam logic [7:0] AUX_CONFIG_RESET = 8'h00;
    localparam int XRAM_DISABLE_BIT = 1;
    localparam logic [7:0] LOW_RAM_TOP = 8'h7F;
    localparam int XRAM_BYTES = 768;
    localparam logic [15:0] XRAM_TOP = 16'h02FF;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // External bus phase lengths.
    localparam int CLK_NS = 100;
    localparam int EXT_ADDR_NS = 200;
    localparam int EXT_STROBE_NS = 300;
    localparam logic [2:0] EXT_ADDR_CYC = 3'((EXT_ADDR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] EXT_STROBE_CYC = 3'((EXT_STROBE_NS + CLK_NS - 1) / CLK_NS);
    // Secondary block mapping per bank-select value.
    localparam logic [1:0] BANK_PRIMARY = 2'h0;
    localparam logic [1:0] BANK_SEC_LOW = 2'h1;
    localparam logic [1:0] BANK_SEC_HIGH = 2'h2;
    localparam logic [2:0] SEC_LOW_TOP = 3'h0;
    localparam logic [2:0] SEC_HIGH_TOP = 3'h7;

    typedef enum logic [2:0] {
        TGT_LOW = 3'b000,
        TGT_UPPER = 3'b001,
        TGT_SFR = 3'b010,
        TGT_XRAM = 3'b011,
        TGT_EXT = 3'b100
    } target_t;

    typedef enum logic [1:0] {
        EXT_IDLE = 2'b00,
        EXT_ADDR = 2'b01,
        EXT_STROBE = 2'b10
    } ext_state_t;

    // True when an external move lands in on-chip expanded RAM.
    function automatic logic xram_hit(input logic disable_bit, input logic [15:0] addr);
        xram_hit = !disable_bit && (addr <= XRAM_TOP);
    endfunction

    // True when the program address is served by the secondary flash block.
    function automatic logic sec_block(input logic [1:0] bank, input logic [15:0] addr);
        case (bank)
            BANK_SEC_LOW: sec_block = (addr[15:13] == SEC_LOW_TOP);
            BANK_SEC_HIGH: sec_block = (addr[15:13] == SEC_HIGH_TOP);
            default: sec_block = 1'b0;
        endcase
    endfunction
endpackage

// [rtl/xbus_if.sv]
// Request carrier between the decoder and its two data memories.
`timescale 1ns/1ps
interface xbus_if;
    logic req;
    logic we;
    logic wide;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    modport ctl(output req, output we, output wide, output addr, output wdata,
                input rdata, input ack);
    modport mem(input req, input we, input wide, input addr, input wdata,
                output rdata, output ack);
endinterface

// [rtl/expanded_ram.sv]
// On-chip 768-byte expanded data RAM reached by external moves.
`timescale 1ns/1ps
module expanded_ram (
    input wire logic aclk,
    input wire logic aresetn,
    xbus_if.mem bus
);
    import memdec_pkg::*;
    logic [7:0] mem_q [XRAM_BYTES];
    logic [7:0] rdata_q;
    logic ack_q;

    // Storage is not reset; software must initialise it like any RAM.
    always_ff @(posedge aclk) begin
        if (bus.req && bus.we) begin
            mem_q[bus.addr[9:0]] <= bus.wdata;
        end
    end

    // Answer one cycle after the request.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus.req;
            if (bus.req && !bus.we) begin
                rdata_q <= mem_q[bus.addr[9:0]];
            end
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.ack = ack_q;
endmodule

// [rtl/external_bus_ctrl.sv]
// Multiplexed address/data external bus sequencer for the low and high ports.
`timescale 1ns/1ps
module external_bus_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    xbus_if.mem bus,
    output logic [7:0] low_port_o,
    input wire logic [7:0] low_port_i,
    output logic low_port_oe,
    output logic [7:0] high_port_o,
    output logic high_port_oe,
    output logic ale,
    output logic wr_n,
    output logic rd_n
);
    import memdec_pkg::*;
    ext_state_t st_q;
    logic [2:0] cnt_q;
    logic we_q;
    logic [7:0] data_q;
    logic [7:0] rdata_q;
    logic ack_q;

    // Address phase with latch enable, then one strobe phase, then release of all pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= EXT_IDLE;
            cnt_q <= 3'h0;
            we_q <= 1'b0;
            data_q <= 8'h00;
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
            low_port_o <= 8'h00;
            low_port_oe <= 1'b0;
            high_port_o <= 8'h00;
            high_port_oe <= 1'b0;
            ale <= 1'b0;
            wr_n <= 1'b1;
            rd_n <= 1'b1;
        end else begin
            ack_q <= 1'b0;
            case (st_q)
                EXT_IDLE: begin
                    if (bus.req) begin
                        st_q <= EXT_ADDR;
                        cnt_q <= EXT_ADDR_CYC - 3'h1;
                        we_q <= bus.we;
                        data_q <= bus.wdata;
                        ale <= 1'b1;
                        low_port_o <= bus.addr[7:0];
                        low_port_oe <= 1'b1;
                        // Narrow moves leave the high port to software paging.
                        high_port_o <= bus.wide ? bus.addr[15:8] : 8'h00;
                        high_port_oe <= bus.wide;
                    end
                end
                EXT_ADDR: begin
                    if (cnt_q == 3'h0) begin
                        st_q <= EXT_STROBE;
                        cnt_q <= EXT_STROBE_CYC - 3'h1;
                        ale <= 1'b0;
                        wr_n <= !we_q;
                        rd_n <= we_q;
                        low_port_o <= we_q ? data_q : 8'h00;
                        low_port_oe <= we_q;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                EXT_STROBE: begin
                    if (cnt_q == 3'h0) begin
                        st_q <= EXT_IDLE;
                        wr_n <= 1'b1;
                        rd_n <= 1'b1;
                        low_port_oe <= 1'b0;
                        high_port_oe <= 1'b0;
                        ack_q <= 1'b1;
                        if (!we_q) begin
                            rdata_q <= low_port_i;
                        end
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: begin
                    st_q <= EXT_IDLE;
                end
            endcase
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.ack = ack_q;
endmodule

// [rtl/memory_space_decoder.sv]
// Program and data space decoder with an AXI4-Lite register slave.
`timescale 1ns/1ps
module memory_space_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic dmem_req,
    input wire logic dmem_direct,
    input wire logic dmem_we,
    input wire logic [7:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    output logic [7:0] dmem_rdata,
    output logic dmem_ack,
    output memdec_pkg::target_t dmem_target,
    output logic sfr_req,
    output logic sfr_we,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic xm_req,
    input wire logic xm_we,
    input wire logic xm_use_data_pointer,
    input wire logic xm_ri_sel,
    input wire logic [7:0] index_reg_zero,
    input wire logic [7:0] index_reg_one,
    input wire logic [15:0] data_pointer,
    input wire logic [7:0] xm_wdata,
    output logic [7:0] xm_rdata,
    output logic xm_ack,
    output logic xm_busy,
    output logic [7:0] low_port_o,
    input wire logic [7:0] low_port_i,
    output logic low_port_oe,
    output logic [7:0] high_port_o,
    output logic high_port_oe,
    output logic ale,
    output logic wr_n,
    output logic rd_n,
    input wire logic [15:0] prog_addr,
    output logic prog_block,
    output logic [8:0] prog_sector,
    output logic [6:0] prog_byte
);
    import memdec_pkg::*;

    logic [7:0] flash_config_q;
    logic [7:0] aux_config_q;
    logic [7:0] iram_q [256];
    logic [7:0] dmem_rdata_q;
    logic dmem_ack_q;
    logic dmem_sfr_q;
    target_t dmem_target_q;
    logic [15:0] xm_addr;
    logic xm_hit;
    logic xm_start;
    logic busy_q;
    logic xr_req_q;
    logic ex_req_q;
    logic x_we_q;
    logic x_wide_q;
    logic [15:0] x_addr_q;
    logic [7:0] x_wdata_q;
    logic [7:0] xm_rdata_q;
    logic xm_ack_q;
    logic xm_last_xram_q;
    logic [1:0] bank;
    logic prog_block_q;
    logic [8:0] prog_sector_q;
    logic [6:0] prog_byte_q;
    logic aw_have_q;
    logic w_have_q;
    logic [9:0] aw_idx_q;
    logic [7:0] w_byte_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [9:0] ar_idx;
    logic wr_fire;

    xbus_if xr_bus();
    xbus_if ex_bus();

    assign bank = flash_config_q[1:0];

    // Internal data RAM; one array holds both the low half and the upper half.
    always_ff @(posedge aclk) begin
        if (dmem_req && dmem_we && !(dmem_direct && dmem_addr[7])) begin
            iram_q[dmem_addr] <= dmem_wdata;
        end
    end

    // Direct accesses above the low half leave on the SFR port in the same cycle.
    assign sfr_req = dmem_req && dmem_direct && dmem_addr[7];
    assign sfr_we = dmem_we;
    assign sfr_addr = dmem_addr;
    assign sfr_wdata = dmem_wdata;

    // Data side answer, one cycle after each request, with the target that served it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dmem_rdata_q <= 8'h00;
            dmem_ack_q <= 1'b0;
            dmem_target_q <= TGT_LOW;
        end else begin
            dmem_ack_q <= dmem_req;
            if (dmem_req) begin
                if (dmem_addr <= LOW_RAM_TOP) begin
                    dmem_target_q <= TGT_LOW;
                    dmem_rdata_q <= iram_q[dmem_addr];
                end else if (dmem_direct) begin
                    dmem_target_q <= TGT_SFR;
                    dmem_rdata_q <= sfr_rdata;
                end else begin
                    dmem_target_q <= TGT_UPPER;
                    dmem_rdata_q <= iram_q[dmem_addr];
                end
            end
        end
    end

    assign dmem_rdata = dmem_rdata_q;
    assign dmem_ack = dmem_ack_q;
    assign dmem_target = dmem_target_q;

    // External move address source and route; a request while busy is ignored.
    assign xm_addr = xm_use_data_pointer ? data_pointer
                   : {8'h00, (xm_ri_sel ? index_reg_one : index_reg_zero)};
    assign xm_hit = xram_hit(aux_config_q[XRAM_DISABLE_BIT], xm_addr);
    assign xm_start = xm_req && !busy_q;

    // Launch one external move to expanded RAM or the external bus and wait for it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            xr_req_q <= 1'b0;
            ex_req_q <= 1'b0;
            x_we_q <= 1'b0;
            x_wide_q <= 1'b0;
            x_addr_q <= 16'h0000;
            x_wdata_q <= 8'h00;
            xm_rdata_q <= 8'h00;
            xm_ack_q <= 1'b0;
            xm_last_xram_q <= 1'b0;
        end else begin
            xr_req_q <= 1'b0;
            ex_req_q <= 1'b0;
            xm_ack_q <= 1'b0;
            if (xm_start) begin
                busy_q <= 1'b1;
                xr_req_q <= xm_hit;
                ex_req_q <= !xm_hit;
                x_we_q <= xm_we;
                x_wide_q <= xm_use_data_pointer;
                x_addr_q <= xm_addr;
                x_wdata_q <= xm_wdata;
                xm_last_xram_q <= xm_hit;
            end else if (busy_q && (xr_bus.ack || ex_bus.ack)) begin
                busy_q <= 1'b0;
                xm_ack_q <= 1'b1;
                xm_rdata_q <= xr_bus.ack ? xr_bus.rdata : ex_bus.rdata;
            end
        end
    end

    assign xr_bus.req = xr_req_q;
    assign xr_bus.we = x_we_q;
    assign xr_bus.wide = x_wide_q;
    assign xr_bus.addr = x_addr_q;
    assign xr_bus.wdata = x_wdata_q;
    assign ex_bus.req = ex_req_q;
    assign ex_bus.we = x_we_q;
    assign ex_bus.wide = x_wide_q;
    assign ex_bus.addr = x_addr_q;
    assign ex_bus.wdata = x_wdata_q;
    assign xm_rdata = xm_rdata_q;
    assign xm_ack = xm_ack_q;
    assign xm_busy = busy_q;

    expanded_ram u_xram (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(xr_bus.mem)
    );

    // Only the external bus sequencer touches the port pins, so expanded RAM stays quiet.
    external_bus_ctrl u_ext (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(ex_bus.mem),
        .low_port_o(low_port_o),
        .low_port_i(low_port_i),
        .low_port_oe(low_port_oe),
        .high_port_o(high_port_o),
        .high_port_oe(high_port_oe),
        .ale(ale),
        .wr_n(wr_n),
        .rd_n(rd_n)
    );

    // Program space split into block, sector and byte; registered for the flash arrays.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_block_q <= 1'b0;
            prog_sector_q <= 9'h000;
            prog_byte_q <= 7'h00;
        end else begin
            prog_block_q <= sec_block(bank, prog_addr);
            prog_byte_q <= prog_addr[6:0];
            if (sec_block(bank, prog_addr)) begin
                prog_sector_q <= {3'h0, prog_addr[12:7]};
            end else begin
                prog_sector_q <= prog_addr[15:7];
            end
        end
    end

    assign prog_block = prog_block_q;
    assign prog_sector = prog_sector_q;
    assign prog_byte = prog_byte_q;

    // Write channel: address and data are taken in either order, answered once both arrive.
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= 10'h000;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (aw_idx_q == FLASH_CONFIG_IDX || aw_idx_q == AUX_CONFIG_IDX
                            || aw_idx_q == STATUS_IDX) ? AXI_OKAY : AXI_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Configuration registers; only byte lane 0 carries the 8-bit fields.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_config_q <= FLASH_CONFIG_RESET;
            aux_config_q <= AUX_CONFIG_RESET;
        end else if (wr_fire && w_lane_q) begin
            if (aw_idx_q == FLASH_CONFIG_IDX) begin
                flash_config_q <= w_byte_q & FLASH_CONFIG_WMASK;
            end
            if (aw_idx_q == AUX_CONFIG_IDX) begin
                aux_config_q <= w_byte_q & (8'h01 << XRAM_DISABLE_BIT);
            end
        end
    end

    // Read channel answers one cycle after the address is taken.
    assign ar_idx = s_axi_araddr[11:2];
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= AXI_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= AXI_OKAY;
            case (ar_idx)
                FLASH_CONFIG_IDX: rdata_q <= {24'h000000, flash_config_q};
                AUX_CONFIG_IDX: rdata_q <= {24'h000000, aux_config_q};
                STATUS_IDX: rdata_q <= {28'h0000000, xm_last_xram_q, dmem_target_q == TGT_LOW,
                                        busy_q, prog_block_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= AXI_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Checks on the routing and pin behaviour.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [6:0] prog_lo;
    assign prog_lo = prog_addr[6:0];

    sequence s_xram_launch;
        xr_req_q ##1 xr_bus.ack;
    endsequence

    sequence s_ext_addr_phase;
        ale [*2] ##1 !ale;
    endsequence

    a_low_ram_both: assert property (dmem_req && dmem_addr <= LOW_RAM_TOP
        |=> dmem_ack && dmem_target == TGT_LOW) else $error("low RAM misrouted");
    a_upper_indirect: assert property (dmem_req && !dmem_direct && dmem_addr[7]
        |=> dmem_target == TGT_UPPER && !$past(sfr_req)) else $error("upper RAM miss");
    a_upper_direct: assert property (dmem_req && dmem_direct && dmem_addr[7]
        |-> sfr_req ##1 dmem_target == TGT_SFR) else $error("SFR miss");
    a_xram_route: assert property (xm_start && !aux_config_q[XRAM_DISABLE_BIT]
        && xm_addr <= XRAM_TOP |=> s_xram_launch ##1 xm_ack) else $error("xram miss");
    a_xram_quiet: assert property (xr_req_q |-> (wr_n && rd_n && !low_port_oe
        && !high_port_oe && !ale) [*3]) else $error("pins moved on xram");
    a_ext_above: assert property (xm_start && xm_addr > XRAM_TOP
        |=> ex_req_q && !xr_req_q) else $error("upper external miss");
    a_ri_narrow: assert property (ex_req_q && !x_wide_q
        |=> s_ext_addr_phase and (!high_port_oe [*3])) else $error("narrow move wide");
    a_data_pointer_wide: assert property (ex_req_q && x_wide_q |=> ale && high_port_oe
        && high_port_o == x_addr_q[15:8] && low_port_o == x_addr_q[7:0]) else
        $error("wide address wrong");
    a_ext_answer: assert property (ex_req_q |-> ##[6:6] ex_bus.ack ##1 xm_ack)
        else $error("external move not answered");
    a_bank_map: assert property (1'b1 |=> prog_block == sec_block($past(bank), $past(prog_addr)))
        else $error("bank map wrong");
    a_sector_split: assert property (1'b1 |=> prog_byte == $past(prog_lo)
        && (!prog_block || prog_sector[8:6] == 3'h0)) else $error("sector split wrong");
endmodule

// [tb/ext_mem_model.sv]
// Behavioural external data memory on the multiplexed port bus.
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic aclk,
    input wire logic ale,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [7:0] low_port_o,
    input wire logic [7:0] high_port_o,
    input wire logic high_port_oe,
    output logic [7:0] low_port_i
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] last_q = 8'h00;
    // Address latch; an undriven high port reads as zero.
    always @(posedge aclk) begin
        if (ale) begin
            addr_q <= {high_port_oe ? high_port_o : 8'h00, low_port_o};
        end
        if (!wr_n) begin
            mem[addr_q] <= low_port_o;
        end
        if (!rd_n) begin
            last_q <= mem[addr_q];
        end
    end
    // A released bus shows the inverse of the last answer.
    assign low_port_i = rd_n ? ~last_q : mem[addr_q];
endmodule

// [tb/memory_space_decoder_tb.sv]
// Self-checking bench for the memory space decoder.
`timescale 1ns/1ps
module memory_space_decoder_tb;
    import memdec_pkg::*;
    typedef struct packed {logic dir; logic we; logic [7:0] a, d, q; target_t t;} row_t;
    logic aclk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wr, bv, arr, rv, dack, sreq, swe, xack, xbusy, loe, hoe, ale, wrn, rdn, pblk;
    logic dreq = 0, ddir = 0, dwe = 0, xreq = 0, xwe = 0, xdp = 0, xri = 0;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] br, rr;
    logic [7:0] da = 0, dwd = 0, drd, r0 = 0, r1 = 0, xwd = 0, xrd, lo, li, ho, sa, sw;
    logic [15:0] dp = 0, pa = 0;
    logic [8:0] psec;
    logic [6:0] pbyte;
    target_t dt;
    int n_errors = 0, comparisons = 0, cyc = 0;
    row_t rows [8] = '{'{0, 1, 8'h10, 8'h11, 8'h00, TGT_LOW}, '{1, 0, 8'h10, 8'h00, 8'h11, TGT_LOW},
        '{0, 1, 8'h90, 8'h22, 8'h00, TGT_UPPER}, '{1, 1, 8'h90, 8'h33, 8'h00, TGT_SFR},
        '{0, 0, 8'h90, 8'h00, 8'h22, TGT_UPPER}, '{1, 0, 8'h90, 8'h00, 8'h5A, TGT_SFR},
        '{1, 1, 8'h7F, 8'h44, 8'h00, TGT_LOW}, '{0, 0, 8'h7F, 8'h00, 8'h44, TGT_LOW}};

    memory_space_decoder memory_space_decoder_inst (.aclk(aclk), .aresetn(rstn),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .dmem_req(dreq),
        .dmem_direct(ddir), .dmem_we(dwe), .dmem_addr(da), .dmem_wdata(dwd),
        .dmem_rdata(drd), .dmem_ack(dack), .dmem_target(dt), .sfr_req(sreq), .sfr_we(swe),
        .sfr_addr(sa), .sfr_wdata(sw), .sfr_rdata(8'h5A), .xm_req(xreq), .xm_we(xwe),
        .xm_use_data_pointer(xdp), .xm_ri_sel(xri), .index_reg_zero(r0), .index_reg_one(r1),
        .data_pointer(dp), .xm_wdata(xwd), .xm_rdata(xrd), .xm_ack(xack), .xm_busy(xbusy),
        .low_port_o(lo), .low_port_i(li), .low_port_oe(loe), .high_port_o(ho),
        .high_port_oe(hoe), .ale(ale), .wr_n(wrn), .rd_n(rdn), .prog_addr(pa),
        .prog_block(pblk), .prog_sector(psec), .prog_byte(pbyte));
    ext_mem_model ext_mem_model_inst (.aclk(aclk), .ale(ale), .wr_n(wrn), .rd_n(rdn),
        .low_port_o(lo), .high_port_o(ho), .high_port_oe(hoe), .low_port_i(li));

    initial begin
        forever #50 aclk = ~aclk;
    end
    // A run takes under a thousand cycles; this cuts a hang short.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            final_report;
        end
    end

    task automatic final_report;
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", n, e, s);
        end
    endtask
    // Tasks wait a cycle first so no strobe falls and rises in one step.
    task automatic axw(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e);
        @(posedge aclk);
        awa <= {i, 2'b00};
        wd <= {24'h0, d};
        awv <= 1;
        wv <= 1;
        bre <= 1;
        forever begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            if (bv) begin
                chk("bresp", e, br);
                bre <= 0;
                break;
            end
        end
    endtask
    task automatic axr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e);
        @(posedge aclk);
        ara <= {i, 2'b00};
        arv <= 1;
        rre <= 1;
        forever begin
            @(posedge aclk);
            if (arr) arv <= 0;
            if (rv) begin
                chk("rdata", {24'h0, d}, rd);
                chk("rresp", e, rr);
                rre <= 0;
                break;
            end
        end
    endtask
    task automatic xm(input logic p, ri, w, input logic [15:0] a, input logic [7:0] d, ext);
        int n;
        logic pins;
        @(posedge aclk);
        {xreq, xdp, xri, xwe, xwd} <= {1'b1, p, ri, w, d};
        dp <= p ? a : ~a;
        r0 <= ri ? ~a[7:0] : a[7:0];
        r1 <= ri ? a[7:0] : ~a[7:0];
        @(posedge aclk);
        xreq <= 0;
        n = 0;
        pins = 0;
        forever begin
            #1;
            n++;
            pins |= ale | !wrn | !rdn | loe | hoe;
            chk("busy", n < (ext ? 8 : 3), xbusy);
            if (xack || n > 20) break;
            @(posedge aclk);
        end
        chk("port activity", ext, pins);
        chk("ack cycle", ext ? 8 : 3, n);
        if (!w) chk("xm_rdata", d, xrd);
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        rstn <= 1;
        axr(FLASH_CONFIG_IDX, 8'h00, AXI_OKAY);
        axr(AUX_CONFIG_IDX, 8'h00, AXI_OKAY);
        axr(10'h000, 8'h00, AXI_SLVERR);
        axw(10'h001, 8'hFF, AXI_SLVERR);
        // Data space: one access a row, checked in its ack cycle.
        foreach (rows[k]) begin
            @(posedge aclk);
            {dreq, ddir, dwe, da, dwd} <= {1'b1, rows[k].dir, rows[k].we, rows[k].a, rows[k].d};
            #1 chk("sfr", {rows[k].dir & rows[k].a[7], rows[k].we, rows[k].a, rows[k].d},
                {sreq, swe, sa, sw});
            @(posedge aclk);
            dreq <= 0;
            #1 chk("dmem_ack", 1, dack);
            chk("target", rows[k].t, dt);
            if (!rows[k].we) chk("dmem_rdata", rows[k].q, drd);
        end
        xm(1, 0, 1, 16'h00A0, 8'h55, 0);
        xm(0, 0, 0, 16'h00A0, 8'h55, 0);
        xm(1, 0, 1, 16'h02FF, 8'h44, 0);
        xm(0, 1, 0, 16'h00A0, 8'h55, 0);
        xm(1, 0, 1, 16'h0300, 8'h99, 1);
        xm(1, 0, 0, 16'h0300, 8'h99, 1);
        axw(AUX_CONFIG_IDX, 8'h02, AXI_OKAY);
        xm(0, 1, 1, 16'h0034, 8'h77, 1);
        xm(1, 0, 1, 16'h1234, 8'h66, 1);
        xm(1, 0, 0, 16'h0034, 8'h77, 1);
        xm(1, 0, 0, 16'h1234, 8'h66, 1);
        axw(FLASH_CONFIG_IDX, 8'hFD, AXI_OKAY);
        axr(FLASH_CONFIG_IDX, 8'h41, AXI_OKAY);
        // Program side: bank, address, then block, sector and byte.
        for (int k = 0; k < 4; k++) begin
            logic [40:0] v;
            v = k[0] ? (k[1] ? {8'h02, 16'hE081, 1'b1, 9'h001, 7'h01}
                : {8'h01, 16'h1F85, 1'b1, 9'h03F, 7'h05})
                : (k[1] ? {8'h02, 16'h1F85, 1'b0, 9'h03F, 7'h05}
                : {8'h03, 16'hFFFF, 1'b0, 9'h1FF, 7'h7F});
            axw(FLASH_CONFIG_IDX, v[40:33], AXI_OKAY);
            pa <= v[32:17];
            repeat (2) @(posedge aclk);
            #1 chk("prog", v[16:0], {pblk, psec, pbyte});
        end
        final_report;
    end
endmodule
